// file: logic/gpm_port_mux_regs.vh
// register map, field positions and reset values of the port and pin mux block
// assumes a 32-bit Avalon-MM slave with byte addresses; every register is one word
`ifndef GPM_PORT_MUX_REGS_VH
`define GPM_PORT_MUX_REGS_VH

// byte offsets
`define GPM_FIRST_LATCH 8'h00
`define GPM_FIRST_DIR 8'h04
`define GPM_SECOND_LATCH 8'h08
`define GPM_SECOND_DIR 8'h0C
`define GPM_THIRD_LATCH 8'h10
`define GPM_THIRD_DIR 8'h14
`define GPM_FOURTH_LATCH 8'h18
`define GPM_FOURTH_DIR 8'h1C
`define GPM_SHARED_PU 8'h20
`define GPM_THIRD_PU 8'h24
`define GPM_THIRD_ALT 8'h28
`define GPM_FOURTH_ALT 8'h2C
`define GPM_SERIAL_MODE 8'h30
`define GPM_EDGE_SEL 8'h34
`define GPM_IRQ_STATUS 8'h38
`define GPM_IRQ_MASK 8'h3C
`define GPM_FIRST_PINS 8'h40
`define GPM_SECOND_PINS 8'h44
`define GPM_THIRD_PINS 8'h48
`define GPM_FOURTH_PINS 8'h4C

// shared pull-up option bit positions
`define GPM_PU_FIRST 0
`define GPM_PU_SECOND 1
`define GPM_PU_FOURTH 3

// serial mode bit: 0 synchronous, 1 asynchronous
`define GPM_MODE_ASYNC 0

// edge select codes, two bits per external interrupt
`define GPM_EDGE_OFF 2'h0
`define GPM_EDGE_RISE 2'h1
`define GPM_EDGE_FALL 2'h2
`define GPM_EDGE_BOTH 2'h3

// reset values: direction 1 means input
`define GPM_DIR_RESET 8'hFF
`define GPM_ZERO 8'h00

`endif

// file: logic/gpm_port_mux.v
// four general-purpose ports with direction, pull-up control and alternate pin functions
// assumes pins synchronous to clk; pad drivers outside resolve out/oe/pullup
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "gpm_port_mux_regs.vh"

// Contract
// R1: first port is 8 bits, each pin input or output by its direction bit.
// R2: first, second, fourth port pull-up only when shared option set and pin is input.
// R3: second port is 6 bits, per-pin direction, shared pull-up option for inputs.
// R4: fourth port is 2 bits, per-pin direction; pins carry wide timer and buzzer.
// R5: third port is 8 bits, per-pin direction, pull-ups from its own option register.
// R6: each external interrupt detects rising, falling or both edges by its select.
// R7: third port bit 0 carries sync serial clock or async baud clock input.
// R8: third port bit 1 carries sync serial data out or async transmit out.
// R9: third port bit 2 carries sync serial data in or async receive in.
// R10: third port bit 3 is the sync serial chip select input when selected.
// R11: third port bit 7 carries event counter clock input or its output.
// R12: fourth bit 0 carries wide timer out; third bit 6 third interrupt or capture.
// R13: after reset every pin is an input and alternate functions are off.
module gpm_port_mux (
	input wire clk,
	input wire reset,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg irq,
	input wire [7:0] first_port_pins_in,
	output reg [7:0] first_port_pins_out,
	output reg [7:0] first_port_pins_oe,
	output reg [7:0] first_port_pullup,
	input wire [5:0] second_port_pins_in,
	output reg [5:0] second_port_pins_out,
	output reg [5:0] second_port_pins_oe,
	output reg [5:0] second_port_pullup,
	input wire [7:0] third_port_pins_in,
	output reg [7:0] third_port_pins_out,
	output reg [7:0] third_port_pins_oe,
	output reg [7:0] third_port_pullup,
	input wire fourth_port_bit0_in,
	output reg fourth_port_bit0_out,
	output reg fourth_port_bit0_oe,
	output reg fourth_port_bit0_pullup,
	input wire fourth_port_bit1_in,
	output reg fourth_port_bit1_out,
	output reg fourth_port_bit1_oe,
	output reg fourth_port_bit1_pullup,
	input wire sync_serial_clock_drive,
	input wire sync_serial_clock_drive_en,
	input wire sync_serial_out,
	input wire async_transmit_out,
	input wire event_counter_out,
	input wire wide_timer_out,
	input wire buzzer_out,
	output reg sync_serial_clock,
	output reg async_baud_clock_in,
	output reg sync_serial_in,
	output reg async_receive_in,
	output reg sync_chip_select_in,
	output reg event_counter_clock_in,
	output reg capture_edge_in,
	output reg ext_irq_a,
	output reg ext_irq_b,
	output reg ext_irq_c
);

	// address compare used by the read mux and every write
	function hit;
		input [7:0] addr;
		input [7:0] offs;
		begin
			hit = (addr == offs);
		end
	endfunction

	reg [7:0] first_lat_reg;
	reg [7:0] first_dir_reg;
	reg [5:0] second_lat_reg;
	reg [5:0] second_dir_reg;
	reg [7:0] third_lat_reg;
	reg [7:0] third_dir_reg;
	reg [1:0] fourth_lat_reg;
	reg [1:0] fourth_dir_reg;
	reg [3:0] shared_pu_reg;
	reg [7:0] third_pu_reg;
	reg [7:0] third_alt_reg;
	reg [1:0] fourth_alt_reg;
	reg serial_mode_reg;
	reg [5:0] edge_sel_reg;
	reg [2:0] irq_stat_reg;
	reg [2:0] irq_mask_reg;
	reg [2:0] irq_prev_reg;
	reg [31:0] rdata_next;
	wire [2:0] irq_stat_next;
	wire [2:0] edge_hit;
	wire [2:0] irq_src;
	wire req;
	wire do_wr;
	wire async_sel;

	assign req = avs_read | avs_write;
	// transfer completes on the edge where the master sees waitrequest low
	assign do_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
	assign async_sel = serial_mode_reg;
	assign irq_src = third_port_pins_in[6:4];

	// edge detectors; only armed once the pin's alternate function is on
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
			wire rise;
			wire fall;
			wire [1:0] sel;
			assign sel = edge_sel_reg[2*gi+1:2*gi];
			assign rise = irq_src[gi] & ~irq_prev_reg[gi];
			assign fall = ~irq_src[gi] & irq_prev_reg[gi];
			assign edge_hit[gi] = third_alt_reg[4+gi] & // [R6]
				((sel == `GPM_EDGE_RISE) & rise |
				(sel == `GPM_EDGE_FALL) & fall |
				(sel == `GPM_EDGE_BOTH) & (rise | fall));
		end
	endgenerate

	// write-one-to-clear, but a new edge in the same cycle wins
	assign irq_stat_next = (irq_stat_reg &
		~((do_wr & hit(avs_address, `GPM_IRQ_STATUS)) ? avs_writedata[2:0] : 3'h0))
		| edge_hit;

	// read mux; unmapped addresses read zero
	always @* begin
		rdata_next = 32'h0000_0000;
		case (1'b1)
			hit(avs_address, `GPM_FIRST_LATCH): rdata_next[7:0] = first_lat_reg;
			hit(avs_address, `GPM_FIRST_DIR): rdata_next[7:0] = first_dir_reg;
			hit(avs_address, `GPM_SECOND_LATCH): rdata_next[5:0] = second_lat_reg;
			hit(avs_address, `GPM_SECOND_DIR): rdata_next[5:0] = second_dir_reg;
			hit(avs_address, `GPM_THIRD_LATCH): rdata_next[7:0] = third_lat_reg;
			hit(avs_address, `GPM_THIRD_DIR): rdata_next[7:0] = third_dir_reg;
			hit(avs_address, `GPM_FOURTH_LATCH): rdata_next[1:0] = fourth_lat_reg;
			hit(avs_address, `GPM_FOURTH_DIR): rdata_next[1:0] = fourth_dir_reg;
			hit(avs_address, `GPM_SHARED_PU): rdata_next[3:0] = shared_pu_reg;
			hit(avs_address, `GPM_THIRD_PU): rdata_next[7:0] = third_pu_reg;
			hit(avs_address, `GPM_THIRD_ALT): rdata_next[7:0] = third_alt_reg;
			hit(avs_address, `GPM_FOURTH_ALT): rdata_next[1:0] = fourth_alt_reg;
			hit(avs_address, `GPM_SERIAL_MODE): rdata_next[0] = serial_mode_reg;
			hit(avs_address, `GPM_EDGE_SEL): rdata_next[5:0] = edge_sel_reg;
			hit(avs_address, `GPM_IRQ_STATUS): rdata_next[2:0] = irq_stat_reg;
			hit(avs_address, `GPM_IRQ_MASK): rdata_next[2:0] = irq_mask_reg;
			hit(avs_address, `GPM_FIRST_PINS): rdata_next[7:0] = first_port_pins_in;
			hit(avs_address, `GPM_SECOND_PINS): rdata_next[5:0] = second_port_pins_in;
			hit(avs_address, `GPM_THIRD_PINS): rdata_next[7:0] = third_port_pins_in;
			hit(avs_address, `GPM_FOURTH_PINS):
				rdata_next[1:0] = {fourth_port_bit1_in, fourth_port_bit0_in};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// bus handshake: one wait cycle, idle waitrequest stays high
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (avs_read & avs_waitrequest)
				avs_readdata <= rdata_next;
		end
	end

	// software registers; direction 1 = input
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			first_dir_reg <= `GPM_DIR_RESET; // [R13]
			second_dir_reg <= 6'h3F; // [R13]
			third_dir_reg <= `GPM_DIR_RESET; // [R13]
			fourth_dir_reg <= 2'h3; // [R13]
			first_lat_reg <= `GPM_ZERO;
			second_lat_reg <= 6'h00;
			third_lat_reg <= `GPM_ZERO;
			fourth_lat_reg <= 2'h0;
			shared_pu_reg <= 4'h0;
			third_pu_reg <= `GPM_ZERO;
			third_alt_reg <= `GPM_ZERO; // [R13]
			fourth_alt_reg <= 2'h0; // [R13]
			serial_mode_reg <= 1'b0;
			edge_sel_reg <= 6'h00;
			irq_mask_reg <= 3'h0;
		end else if (do_wr) begin
			if (hit(avs_address, `GPM_FIRST_LATCH))
				first_lat_reg <= avs_writedata[7:0];
			if (hit(avs_address, `GPM_FIRST_DIR))
				first_dir_reg <= avs_writedata[7:0]; // [R1]
			if (hit(avs_address, `GPM_SECOND_LATCH))
				second_lat_reg <= avs_writedata[5:0];
			if (hit(avs_address, `GPM_SECOND_DIR))
				second_dir_reg <= avs_writedata[5:0]; // [R3]
			if (hit(avs_address, `GPM_THIRD_LATCH))
				third_lat_reg <= avs_writedata[7:0];
			if (hit(avs_address, `GPM_THIRD_DIR))
				third_dir_reg <= avs_writedata[7:0]; // [R5]
			if (hit(avs_address, `GPM_FOURTH_LATCH))
				fourth_lat_reg <= avs_writedata[1:0];
			if (hit(avs_address, `GPM_FOURTH_DIR))
				fourth_dir_reg <= avs_writedata[1:0]; // [R4]
			if (hit(avs_address, `GPM_SHARED_PU))
				shared_pu_reg <= avs_writedata[3:0];
			if (hit(avs_address, `GPM_THIRD_PU))
				third_pu_reg <= avs_writedata[7:0];
			if (hit(avs_address, `GPM_THIRD_ALT))
				third_alt_reg <= avs_writedata[7:0];
			if (hit(avs_address, `GPM_FOURTH_ALT))
				fourth_alt_reg <= avs_writedata[1:0];
			if (hit(avs_address, `GPM_SERIAL_MODE))
				serial_mode_reg <= avs_writedata[`GPM_MODE_ASYNC];
			if (hit(avs_address, `GPM_EDGE_SEL))
				edge_sel_reg <= avs_writedata[5:0];
			if (hit(avs_address, `GPM_IRQ_MASK))
				irq_mask_reg <= avs_writedata[2:0];
		end
	end

	// interrupt status, edge history and level interrupt
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_stat_reg <= 3'h0;
			irq_prev_reg <= 3'h0;
			irq <= 1'b0;
			ext_irq_a <= 1'b0;
			ext_irq_b <= 1'b0;
			ext_irq_c <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_prev_reg <= irq_src;
			irq <= |(irq_stat_next & irq_mask_reg);
			ext_irq_a <= edge_hit[0]; // [R6]
			ext_irq_b <= edge_hit[1]; // [R6]
			ext_irq_c <= edge_hit[2]; // [R6] [R12]
		end
	end

	// pad drive for the plain ports; pull-up only on input pins
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			first_port_pins_out <= `GPM_ZERO;
			first_port_pins_oe <= `GPM_ZERO;
			first_port_pullup <= `GPM_ZERO;
			second_port_pins_out <= 6'h00;
			second_port_pins_oe <= 6'h00;
			second_port_pullup <= 6'h00;
		end else begin
			first_port_pins_out <= first_lat_reg;
			first_port_pins_oe <= ~first_dir_reg; // [R1]
			first_port_pullup <= {8{shared_pu_reg[`GPM_PU_FIRST]}} & first_dir_reg; // [R2]
			second_port_pins_out <= second_lat_reg;
			second_port_pins_oe <= ~second_dir_reg; // [R3]
			second_port_pullup <= {6{shared_pu_reg[`GPM_PU_SECOND]}} & second_dir_reg; // [R2] [R3]
		end
	end

	// third port pads; input-only alternates force the pin off the bus
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			third_port_pins_out <= `GPM_ZERO;
			third_port_pins_oe <= `GPM_ZERO;
			third_port_pullup <= `GPM_ZERO;
		end else begin
			third_port_pins_out[0] <= third_alt_reg[0] ? sync_serial_clock_drive
				: third_lat_reg[0]; // [R7]
			third_port_pins_out[1] <= third_alt_reg[1] ?
				(async_sel ? async_transmit_out : sync_serial_out) : third_lat_reg[1]; // [R8]
			third_port_pins_out[6:2] <= third_lat_reg[6:2];
			third_port_pins_out[7] <= third_alt_reg[7] ? event_counter_out
				: third_lat_reg[7]; // [R11]
			// serial clock drives only as sync master; baud clock is input only
			third_port_pins_oe[0] <= third_alt_reg[0] ?
				(~async_sel & sync_serial_clock_drive_en) : ~third_dir_reg[0]; // [R7]
			third_port_pins_oe[1] <= ~third_dir_reg[1]; // [R8]
			third_port_pins_oe[6:2] <= ~third_dir_reg[6:2] & ~third_alt_reg[6:2]; // [R9] [R10]
			third_port_pins_oe[7] <= ~third_dir_reg[7]; // [R11]
			// these pull-ups ignore direction, unlike the shared option
			third_port_pullup <= third_pu_reg; // [R5]
		end
	end

	// fourth port pads
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			fourth_port_bit0_out <= 1'b0;
			fourth_port_bit0_oe <= 1'b0;
			fourth_port_bit0_pullup <= 1'b0;
			fourth_port_bit1_out <= 1'b0;
			fourth_port_bit1_oe <= 1'b0;
			fourth_port_bit1_pullup <= 1'b0;
		end else begin
			fourth_port_bit0_out <= fourth_alt_reg[0] ? wide_timer_out
				: fourth_lat_reg[0]; // [R4] [R12]
			fourth_port_bit1_out <= fourth_alt_reg[1] ? buzzer_out
				: fourth_lat_reg[1]; // [R4]
			fourth_port_bit0_oe <= ~fourth_dir_reg[0]; // [R4]
			fourth_port_bit1_oe <= ~fourth_dir_reg[1]; // [R4]
			fourth_port_bit0_pullup <= shared_pu_reg[`GPM_PU_FOURTH] & fourth_dir_reg[0]; // [R2]
			fourth_port_bit1_pullup <= shared_pu_reg[`GPM_PU_FOURTH] & fourth_dir_reg[1]; // [R2]
		end
	end

	// inputs toward the peripheral units; unselected paths rest low
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_serial_clock <= 1'b0;
			async_baud_clock_in <= 1'b0;
			sync_serial_in <= 1'b0;
			async_receive_in <= 1'b0;
			sync_chip_select_in <= 1'b0;
			event_counter_clock_in <= 1'b0;
			capture_edge_in <= 1'b0;
		end else begin
			sync_serial_clock <= third_alt_reg[0] & ~async_sel & third_port_pins_in[0]; // [R7]
			async_baud_clock_in <= third_alt_reg[0] & async_sel & third_port_pins_in[0]; // [R7]
			sync_serial_in <= third_alt_reg[2] & ~async_sel & third_port_pins_in[2]; // [R9]
			async_receive_in <= third_alt_reg[2] & async_sel & third_port_pins_in[2]; // [R9]
			sync_chip_select_in <= third_alt_reg[3] & third_port_pins_in[3]; // [R10]
			// counter clock only while pin is an input, else it rests low and never feeds back its own output
			event_counter_clock_in <= third_alt_reg[7] & third_dir_reg[7]
				& third_port_pins_in[7]; // [R11]
			capture_edge_in <= third_alt_reg[6] & third_port_pins_in[6]; // [R12]
		end
	end

endmodule

// file: test/gpm_port_mux_properties.sv
// concurrent checks on the port mux block: bus handshake, pull-ups, pin routing
// sees only the top module's ports; attached to every instance by the bind below
`timescale 1ns/1ps
module gpm_port_mux_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic [7:0] first_port_pins_oe,
	input wire logic [7:0] first_port_pullup,
	input wire logic [5:0] second_port_pins_oe,
	input wire logic [5:0] second_port_pullup,
	input wire logic [7:0] third_port_pins_in,
	input wire logic [7:0] third_port_pins_oe,
	input wire logic fourth_port_bit0_oe,
	input wire logic fourth_port_bit0_pullup,
	input wire logic fourth_port_bit1_oe,
	input wire logic fourth_port_bit1_pullup,
	input wire logic sync_serial_clock,
	input wire logic async_baud_clock_in,
	input wire logic sync_serial_in,
	input wire logic async_receive_in,
	input wire logic sync_chip_select_in,
	input wire logic event_counter_clock_in,
	input wire logic capture_edge_in,
	input wire logic ext_irq_a
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// a taken request is answered after exactly one wait cycle, then idles high
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence s_idle;
		(first_port_pins_oe == 8'h00) && (second_port_pins_oe == 6'h00) &&
			(third_port_pins_oe == 8'h00) && !fourth_port_bit0_oe && !fourth_port_bit1_oe;
	endsequence
	a_bus_one_wait: assert property (s_req |=> s_ans)
		else $error("bus answer not after one wait cycle");
	a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	a_pull_input_only: assert property (((first_port_pullup & first_port_pins_oe) == 8'h00) &&
		((second_port_pullup & second_port_pins_oe) == 6'h00) &&
		!(fourth_port_bit0_pullup && fourth_port_bit0_oe) && !(fourth_port_bit1_pullup && fourth_port_bit1_oe))
		else $error("pull-up on a driven pin");
	a_reset_all_inputs: assert property ($fell(reset) |-> s_idle [*2])
		else $error("pin driven right after reset");
	a_clock_mux: assert property ((sync_serial_clock || async_baud_clock_in) |->
		!(sync_serial_clock && async_baud_clock_in) && $past(third_port_pins_in[0]))
		else $error("serial clock input routing wrong");
	a_data_in_mux: assert property ((sync_serial_in || async_receive_in) |->
		!(sync_serial_in && async_receive_in) && $past(third_port_pins_in[2]))
		else $error("serial data input routing wrong");
	a_select_source: assert property (sync_chip_select_in |-> $past(third_port_pins_in[3]))
		else $error("chip select not from its pin");
	a_count_source: assert property (event_counter_clock_in |-> $past(third_port_pins_in[7]))
		else $error("count clock not from its pin");
	a_capture_source: assert property (capture_edge_in |-> $past(third_port_pins_in[6]))
		else $error("capture input not from its pin");
	a_irq_edge_seen: assert property (ext_irq_a |->
		($past(third_port_pins_in[4], 1) != $past(third_port_pins_in[4], 2)) ||
		($past(third_port_pins_in[4], 2) != $past(third_port_pins_in[4], 3)) ||
		($past(third_port_pins_in[4], 3) != $past(third_port_pins_in[4], 4)))
		else $error("interrupt pulse without a pin edge");
endmodule

bind gpm_port_mux gpm_port_mux_properties u_props (.*);

// file: test/gpm_board.sv
// board side of one port: resolves each pin from chip drive, board drive and pull-up
// where the bench and the chip both drive a pin, the chip's drive wins
`timescale 1ns/1ps
module gpm_board #(parameter int W = 8) (
	input wire logic clk,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pu_on,
	input wire logic [W-1:0] ext,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] pin
);
	logic [W-1:0] flt = '0;
	// an undriven pin without pull-up wanders, so a missing pull-up cannot read as a steady 1
	always @(posedge clk) flt <= ~flt;
	assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu_on | flt));
endmodule

// file: test/gpm_port_mux_tb.sv
// self-checking bench for the port mux block: register tasks, pin and interrupt checks
// assumes an Avalon slave with waitrequest and the register map of the design header
`timescale 1ns/1ps
`include "gpm_port_mux_regs.vh"
module gpm_port_mux_tb;
	logic clk = 1'h0, reset = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic sync_serial_clock_drive = 1'h0, sync_serial_clock_drive_en = 1'h0;
	logic sync_serial_out = 1'h0, async_transmit_out = 1'h0, event_counter_out = 1'h0;
	logic wide_timer_out = 1'h0, buzzer_out = 1'h0;
	logic [7:0] avs_address = 8'h00, e1 = 8'h00, en1 = 8'h00, e3 = 8'h00, pulses, p0;
	logic [31:0] avs_writedata = 32'h0, rdata;
	logic [3:0] avs_byteenable = 4'hF;
	int compares = 0, mismatches = 0;
	wire [31:0] avs_readdata;
	wire [7:0] first_port_pins_in, first_port_pins_out, first_port_pins_oe, first_port_pullup;
	wire [7:0] third_port_pins_in, third_port_pins_out, third_port_pins_oe, third_port_pullup;
	wire [5:0] second_port_pins_in, second_port_pins_out, second_port_pins_oe, second_port_pullup;
	wire [1:0] p4;
	wire [7:0] oe_all, units;
	wire avs_waitrequest, irq, fourth_port_bit0_in, fourth_port_bit0_out, fourth_port_bit0_oe;
	wire fourth_port_bit0_pullup, fourth_port_bit1_in, fourth_port_bit1_out, fourth_port_bit1_oe;
	wire fourth_port_bit1_pullup, sync_serial_clock, async_baud_clock_in, sync_serial_in;
	wire async_receive_in, sync_chip_select_in, event_counter_clock_in, capture_edge_in;
	wire ext_irq_a, ext_irq_b, ext_irq_c;
	assign fourth_port_bit0_in = p4[0];
	assign fourth_port_bit1_in = p4[1];
	assign oe_all = first_port_pins_oe | {2'h0, second_port_pins_oe} | third_port_pins_oe |
		{6'h0, fourth_port_bit1_oe, fourth_port_bit0_oe};
	assign units = {2'h0, sync_serial_clock, async_baud_clock_in, sync_serial_in,
		async_receive_in, event_counter_clock_in, capture_edge_in};
	gpm_port_mux dut (.*);
	gpm_board #(8) b1 (.clk(clk), .out(first_port_pins_out), .oe(first_port_pins_oe),
		.pu_on(first_port_pullup), .ext(e1), .ext_en(en1), .pin(first_port_pins_in));
	gpm_board #(6) b2 (.clk(clk), .out(second_port_pins_out), .oe(second_port_pins_oe),
		.pu_on(second_port_pullup), .ext(6'h00), .ext_en(6'h00), .pin(second_port_pins_in));
	gpm_board #(8) b3 (.clk(clk), .out(third_port_pins_out), .oe(third_port_pins_oe),
		.pu_on(third_port_pullup), .ext(e3), .ext_en(8'hFF), .pin(third_port_pins_in));
	gpm_board #(2) b4 (.clk(clk), .out({fourth_port_bit1_out, fourth_port_bit0_out}),
		.oe({fourth_port_bit1_oe, fourth_port_bit0_oe}), .ext(2'h0), .ext_en(2'h0),
		.pu_on({fourth_port_bit1_pullup, fourth_port_bit0_pullup}), .pin(p4));
	always #20 clk = ~clk;
	// counts every external interrupt pulse so tests can take differences
	always @(posedge clk) pulses <= reset ? 8'h00 : pulses + ext_irq_a + ext_irq_b + ext_irq_c;
	// one Avalon transfer: hold the request until waitrequest is sampled low
	// no cycle count is assumed; only the watchdog ends a wait that never finishes
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		rdata = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		compares++;
		if (rdata !== e) begin
			mismatches++;
			$display("[ERR] reg %h expected %h seen %h", a, e, rdata);
		end
	endtask
	task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// about 400 cycles of tests; the limit of 20000 cycles leaves ample margin
	initial begin
		#800000;
		mismatches++;
		test_done();
	end
	initial begin
		reset <= 1'h1;
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		chk_pin("oe", 8'h00, oe_all);
		chk_pin("units", 8'h00, units);
		chk_reg(`GPM_FIRST_DIR, 32'hFF);
		chk_reg(`GPM_SECOND_DIR, 32'h3F);
		chk_reg(`GPM_THIRD_DIR, 32'hFF);
		chk_reg(`GPM_FOURTH_DIR, 32'h3);
		chk_reg(`GPM_THIRD_ALT, 32'h0);
		chk_reg(8'h50, 32'h0);
		$display("test reset done");
		e1 <= 8'h03;
		en1 <= 8'h0F;
		bus(1'h1, `GPM_FIRST_LATCH, 32'hA5);
		bus(1'h1, `GPM_FIRST_DIR, 32'h0F);
		repeat (2) @(posedge clk);
		chk_pin("first oe", 8'hF0, first_port_pins_oe);
		chk_reg(`GPM_FIRST_PINS, 32'hA3);
		en1 <= 8'h00;
		bus(1'h1, `GPM_SHARED_PU, 32'hB);
		bus(1'h1, `GPM_THIRD_PU, 32'h81);
		bus(1'h1, `GPM_THIRD_DIR, 32'h7F);
		bus(1'h1, `GPM_FOURTH_DIR, 32'h1);
		bus(1'h1, `GPM_SECOND_LATCH, 32'h05);
		bus(1'h1, `GPM_SECOND_DIR, 32'h30);
		repeat (2) @(posedge clk);
		chk_pin("first pu", 8'h0F, first_port_pullup);
		chk_pin("second pu", 8'h30, {2'h0, second_port_pullup});
		chk_pin("second oe", 8'h0F, {2'h0, second_port_pins_oe});
		chk_pin("fourth pu", 8'h1, {6'h0, fourth_port_bit1_pullup, fourth_port_bit0_pullup});
		chk_pin("third pu", 8'h81, third_port_pullup);
		chk_reg(`GPM_FIRST_PINS, 32'hAF);
		chk_reg(`GPM_SECOND_PINS, 32'h35);
		$display("test ports done");
		e3 <= 8'hCD;
		wide_timer_out <= 1'h1;
		async_transmit_out <= 1'h1;
		buzzer_out <= 1'h1;
		sync_serial_clock_drive <= 1'h1;
		sync_serial_clock_drive_en <= 1'h1;
		bus(1'h1, `GPM_THIRD_ALT, 32'hCF);
		bus(1'h1, `GPM_FOURTH_ALT, 32'h3);
		bus(1'h1, `GPM_FOURTH_DIR, 32'h0);
		bus(1'h1, `GPM_THIRD_DIR, 32'hFD);
		for (int m = 0; m < 2; m++) begin
			bus(1'h1, `GPM_SERIAL_MODE, 32'(m));
			repeat (3) @(posedge clk);
			chk_pin("units", (m == 1) ? 8'h17 : 8'h2B, units);
			chk_pin("shared out", 8'(m), {7'h0, third_port_pins_out[1]});
			chk_pin("clock pad", {6'h0, m == 0, 1'h1}, {6'h0, third_port_pins_oe[0], third_port_pins_out[0]});
			if (m == 0) chk_pin("select", 8'h1, {7'h0, sync_chip_select_in});
		end
		chk_pin("fourth", 8'h33, {2'h0, fourth_port_bit1_oe, fourth_port_bit0_oe, 2'h0,
			fourth_port_bit1_out, fourth_port_bit0_out});
		event_counter_out <= 1'h1;
		bus(1'h1, `GPM_THIRD_DIR, 32'h7D);
		repeat (3) @(posedge clk);
		chk_pin("count out", 8'h80, {third_port_pins_out[7] & third_port_pins_oe[7], 6'h0,
			event_counter_clock_in});
		$display("test alternates done");
		e3 <= 8'h00;
		repeat (4) @(posedge clk);
		bus(1'h1, `GPM_THIRD_ALT, 32'h70);
		bus(1'h1, `GPM_IRQ_MASK, 32'h7);
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 4; c++) begin
				bus(1'h1, `GPM_EDGE_SEL, 32'(c << (2 * i)));
				p0 = pulses;
				e3[4 + i] <= 1'h1;
				repeat (5) @(posedge clk);
				e3[4 + i] <= 1'h0;
				repeat (5) @(posedge clk);
				chk_pin("pulses", (c == 3) ? 8'h2 : ((c != 0) ? 8'h1 : 8'h0), pulses - p0);
				chk_pin("irq", {7'h0, c != 0}, {7'h0, irq});
				chk_reg(`GPM_IRQ_STATUS, (c != 0) ? 32'h1 << i : 32'h0);
				bus(1'h1, `GPM_IRQ_STATUS, 32'h7);
				chk_reg(`GPM_IRQ_STATUS, 32'h0);
			end
		end
		bus(1'h1, `GPM_IRQ_MASK, 32'h0);
		bus(1'h1, `GPM_EDGE_SEL, 32'h3);
		e3[4] <= 1'h1;
		repeat (5) @(posedge clk);
		chk_pin("irq masked", 8'h0, {7'h0, irq});
		chk_reg(`GPM_IRQ_STATUS, 32'h1);
		$display("test interrupts done");
		test_done();
	end
endmodule
